//--- rtl/sos_defs.svh
// Offsets, field positions and reset values of the strap override selector
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH
`define SOS_CMD_OVERRIDE 8'hd8
`define SOS_BIT_ALL 15
`define SOS_BIT_SS 11
`define SOS_BIT_FLT 10
`define SOS_BIT_ADDR 9
`define SOS_BIT_MODE 6
`define SOS_BIT_FSW 5
`define SOS_BIT_RAMP 4
`define SOS_BIT_GAIN 3
`define SOS_BIT_OCL 2
`define SOS_BIT_VOLT 0
`define SOS_WR_MASK 16'h8e7d
`define SOS_WORD_RST 16'h0000
`define SOS_NFUNC 9
`endif

//--- rtl/sos_pkg.sv
// Types shared by the strap override selector
package sos_pkg;
  typedef enum logic [1:0] {
    SOS_WAIT = 2'b00,
    SOS_EVAL = 2'b01,
    SOS_DONE = 2'b10
  } sos_state_e;
  // One flag per function: 1 selects the stored value
  typedef struct packed {
    logic softstart;
    logic fault_reply;
    logic bus_address;
    logic light_load;
    logic switching_rate;
    logic ramp;
    logic gain;
    logic current_limit;
    logic voltage_select;
  } sos_sel_s;
  // Host writes of commands that retire a stored value
  typedef struct packed {
    logic ton_rise;
    logic fault_resp;
    logic bus_addr;
    logic user_sys_cfg;
    logic freq_switch;
    logic comp;
    logic oc_limit;
    logic vout_group;
  } sos_cmdwr_s;
endpackage

//--- rtl/sos_sync.sv
// Three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sos_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_q <= s3_q;
      end
    end
  end

  assign q_o = q_q;
endmodule
`default_nettype wire

//--- rtl/sos_top.sv
// Strap override word and per-function strap or stored value selection
`timescale 1ns/1ps
`default_nettype none
`include "sos_defs.svh"
module sos_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_WRITE_I,
  input wire logic [7:0] CMD_CODE_I,
  input wire logic [15:0] CMD_WDATA_I,
  input wire logic NVM_VALID_I,
  input wire logic [15:0] NVM_WORD_I,
  input wire logic EXT_DIVIDER_I,
  input wire sos_pkg::sos_cmdwr_s CMD_WR_I,
  output logic [15:0] CMD_RDATA_O,
  output logic CMD_ACK_O,
  output logic [15:0] ACTIVE_WORD_O,
  output var sos_pkg::sos_sel_s USE_STORED_O,
  output logic SELECT_DONE_O
);
  sos_pkg::sos_state_e state_q;
  logic [15:0] word_q;
  logic [15:0] active_q;
  logic [15:0] rdata_q;
  logic ack_q;
  sos_pkg::sos_sel_s sel_q;
  sos_pkg::sos_sel_s sel_d;
  logic done_q;
  logic ext_div_s;
  logic hit;

  // Strap mode pin comes from outside the clock domain
  sos_sync #(.W(1)) u_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(EXT_DIVIDER_I),
    .q_o(ext_div_s)
  );

  function automatic logic [15:0] legal(input logic [15:0] w);
    legal = w & `SOS_WR_MASK;
  endfunction

  assign hit = CMD_VALID_I && (CMD_CODE_I == `SOS_CMD_OVERRIDE);

  // Override word: loaded from NVM, then host writable on the fly
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      word_q <= `SOS_WORD_RST;
    end else if (hit && CMD_WRITE_I) begin
      word_q <= legal(CMD_WDATA_I);
    end else if (state_q == sos_pkg::SOS_WAIT && NVM_VALID_I) begin
      word_q <= legal(NVM_WORD_I);
    end
  end

  // Read path answers one cycle after the request
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= hit;
      if (hit && !CMD_WRITE_I) begin
        rdata_q <= word_q;
      end
    end
  end

  // Evaluation happens once; later host writes wait for store and power cycle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= sos_pkg::SOS_WAIT;
    end else begin
      case (state_q)
        sos_pkg::SOS_WAIT: begin
          if (NVM_VALID_I) begin
            state_q <= sos_pkg::SOS_EVAL;
          end
        end
        sos_pkg::SOS_EVAL: state_q <= sos_pkg::SOS_DONE;
        sos_pkg::SOS_DONE: state_q <= sos_pkg::SOS_DONE;
        default: state_q <= sos_pkg::SOS_WAIT;
      endcase
    end
  end

  always_comb begin
    logic all;
    all = active_q[`SOS_BIT_ALL];
    sel_d.softstart = all | active_q[`SOS_BIT_SS];
    sel_d.fault_reply = all | active_q[`SOS_BIT_FLT];
    sel_d.bus_address = all | active_q[`SOS_BIT_ADDR];
    sel_d.light_load = all | active_q[`SOS_BIT_MODE];
    sel_d.switching_rate = all | active_q[`SOS_BIT_FSW];
    sel_d.ramp = all | active_q[`SOS_BIT_RAMP];
    sel_d.gain = all | active_q[`SOS_BIT_GAIN];
    sel_d.current_limit = all | active_q[`SOS_BIT_OCL];
    // External divider makes the voltage strap meaningless
    sel_d.voltage_select = all | active_q[`SOS_BIT_VOLT] | ext_div_s;
  end

  // Snapshot of the restored word, the one evaluated this power-up
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      active_q <= `SOS_WORD_RST;
    end else if (state_q == sos_pkg::SOS_WAIT && NVM_VALID_I) begin
      active_q <= legal(NVM_WORD_I);
    end
  end

  // A stored value stays chosen until its command is written; then the written value governs
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sel_q <= '0;
      done_q <= 1'b0;
    end else if (state_q == sos_pkg::SOS_EVAL) begin
      sel_q <= sel_d;
      done_q <= 1'b1;
    end else if (state_q == sos_pkg::SOS_DONE) begin
      if (CMD_WR_I.ton_rise) sel_q.softstart <= 1'b0;
      if (CMD_WR_I.fault_resp) sel_q.fault_reply <= 1'b0;
      if (CMD_WR_I.bus_addr) sel_q.bus_address <= 1'b0;
      if (CMD_WR_I.user_sys_cfg) sel_q.light_load <= 1'b0;
      if (CMD_WR_I.freq_switch) sel_q.switching_rate <= 1'b0;
      if (CMD_WR_I.comp) sel_q.ramp <= 1'b0;
      if (CMD_WR_I.comp) sel_q.gain <= 1'b0;
      if (CMD_WR_I.oc_limit) sel_q.current_limit <= 1'b0;
      if (CMD_WR_I.vout_group) sel_q.voltage_select <= 1'b0;
    end
  end

  assign CMD_RDATA_O = rdata_q;
  assign CMD_ACK_O = ack_q;
  assign ACTIVE_WORD_O = active_q;
  assign USE_STORED_O = sel_q;
  assign SELECT_DONE_O = done_q;

  chk_read_zero_bits: assert property (@(posedge CLK_I) disable iff (RST_I)
    (rdata_q & ~16'h8e7d) == 16'h0000) else $error("Unsupported bits read nonzero");
  chk_write_drop_bits: assert property (@(posedge CLK_I) disable iff (RST_I)
    hit && CMD_WRITE_I |=> word_q == ($past(CMD_WDATA_I) & 16'h8e7d))
    else $error("Write not masked");
  chk_read_answer: assert property (@(posedge CLK_I) disable iff (RST_I)
    hit && !CMD_WRITE_I |=> ack_q && rdata_q == $past(word_q)) else $error("Bad read answer");
  sequence s_restore;
    state_q == sos_pkg::SOS_WAIT && NVM_VALID_I;
  endsequence
  chk_eval_once: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_restore ##2 1'b1 |-> done_q) else $error("Selection not latched");
  chk_bypass_all: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_EVAL && active_q[15] |=> sel_q.ramp && sel_q.gain
    && sel_q.bus_address) else $error("Global bypass ignored");
  chk_strap_default: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_EVAL && active_q == 16'h0000 |=> !sel_q.softstart
    && !sel_q.current_limit) else $error("Strap not preferred");
  chk_stored_used: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_EVAL && active_q[5] |=> sel_q.switching_rate)
    else $error("Stored frequency not chosen");
  chk_no_reeval: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && hit && CMD_WRITE_I |=> $stable(active_q))
    else $error("Write took effect without power cycle");
  chk_comp_retire: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.comp |=> !sel_q.ramp && !sel_q.gain)
    else $error("Compensation write did not retire stored value");

  // Evaluation edge with the global bypass clear: each flag follows its own bit, voltage select ORed with the divider strap
  sequence s_eval_edge;
    state_q == sos_pkg::SOS_EVAL && !active_q[`SOS_BIT_ALL];
  endsequence
  // Settled selection with no retiring command in flight
  sequence s_done_idle;
    state_q == sos_pkg::SOS_DONE && CMD_WR_I == '0;
  endsequence

  chk_eval_softstart: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.softstart == active_q[`SOS_BIT_SS])
    else $error("Rise time selection wrong");

  chk_eval_fault_reply: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.fault_reply == active_q[`SOS_BIT_FLT])
    else $error("Fault response selection wrong");

  chk_eval_bus_address: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.bus_address == active_q[`SOS_BIT_ADDR])
    else $error("Bus address selection wrong");

  chk_eval_light_load: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.light_load == active_q[`SOS_BIT_MODE])
    else $error("Light-load selection wrong");

  chk_eval_switching_rate: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.switching_rate == active_q[`SOS_BIT_FSW])
    else $error("Frequency selection wrong");

  chk_eval_ramp: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.ramp == active_q[`SOS_BIT_RAMP])
    else $error("Ramp selection wrong");

  chk_eval_gain: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.gain == active_q[`SOS_BIT_GAIN])
    else $error("Gain selection wrong");

  chk_eval_current_limit: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.current_limit == active_q[`SOS_BIT_OCL])
    else $error("Current limit selection wrong");

  // The divider strap is the synchronised level seen at the evaluation edge
  chk_eval_voltage_select: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_eval_edge |=> sel_q.voltage_select == (active_q[`SOS_BIT_VOLT] | $past(ext_div_s)))
    else $error("Voltage selection wrong");

  chk_divider_forces: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_EVAL && ext_div_s |=> sel_q.voltage_select)
    else $error("External divider did not force stored voltage");

  chk_retire_rise: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.ton_rise |=> !sel_q.softstart)
    else $error("Rise time write did not retire stored value");

  chk_retire_fault: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.fault_resp |=> !sel_q.fault_reply)
    else $error("Fault response write did not retire stored value");

  chk_retire_address: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.bus_addr |=> !sel_q.bus_address)
    else $error("Address write did not retire stored value");

  chk_retire_light_load: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.user_sys_cfg |=> !sel_q.light_load)
    else $error("Configuration write did not retire stored value");

  chk_retire_rate: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.freq_switch |=> !sel_q.switching_rate)
    else $error("Frequency write did not retire stored value");

  chk_retire_limit: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.oc_limit |=> !sel_q.current_limit)
    else $error("Limit write did not retire stored value");

  chk_retire_voltage: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q == sos_pkg::SOS_DONE && CMD_WR_I.vout_group |=> !sel_q.voltage_select)
    else $error("Voltage write did not retire stored value");

  // Nothing but a retiring pulse may move a latched selection
  chk_sel_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_done_idle |=> $stable(sel_q))
    else $error("Selection changed without a retiring write");

  chk_done_sticky: assert property (@(posedge CLK_I) disable iff (RST_I)
    done_q |=> done_q && state_q == sos_pkg::SOS_DONE)
    else $error("Selection done dropped before reset");

  chk_eval_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_restore |=> state_q == sos_pkg::SOS_EVAL)
    else $error("Restore did not start evaluation");

  chk_restore_mask: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_restore |=> active_q == ($past(NVM_WORD_I) & 16'h8e7d))
    else $error("Restored word not masked");

  chk_restore_once: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_q != sos_pkg::SOS_WAIT |=> $stable(active_q))
    else $error("Evaluated word changed after restore");

  chk_ack_refused: assert property (@(posedge CLK_I) disable iff (RST_I)
    !hit |=> !ack_q)
    else $error("Acknowledge without a served request");

  chk_ack_write: assert property (@(posedge CLK_I) disable iff (RST_I)
    hit && CMD_WRITE_I |=> ack_q)
    else $error("Write not acknowledged");

  chk_rdata_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !(hit && !CMD_WRITE_I) |=> $stable(rdata_q))
    else $error("Read data moved without a read");

  chk_word_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !(hit && CMD_WRITE_I) && !(state_q == sos_pkg::SOS_WAIT && NVM_VALID_I) |=> $stable(word_q))
    else $error("Override word moved without a write");

  // A reset stands for the power cycle, so it must clear every selection
  chk_reset_clear: assert property (@(posedge CLK_I)
    RST_I |=> !done_q && !ack_q && sel_q == '0 && state_q == sos_pkg::SOS_WAIT)
    else $error("Reset left selection state behind");

endmodule
`default_nettype wire

//--- testbench/sos_host.sv
// Host model that issues word reads and writes on the command port
`timescale 1ns/1ps
`default_nettype none
module sos_host (
  input wire logic clk_i,
  input wire logic cmd_ack_i,
  input wire logic [15:0] cmd_rdata_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_wdata_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end
  // Idle gap first, so the host can be prompt or slow
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      input int gap, output logic [15:0] rd, output logic ack);
    repeat (gap + 1) @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o = code;
    cmd_wdata_o = wd;
    @(posedge clk_i);
    #1;
    ack = cmd_ack_i;
    rd = cmd_rdata_i;
    cmd_valid_o = 1'b0;
    // Released lines carry the inverse so stale data cannot pass for fresh
    cmd_wdata_o = ~wd;
    cmd_code_o = ~code;
  endtask
endmodule
`default_nettype wire

//--- testbench/sos_top_bench.sv
// Self-checking bench for the strap override selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module sos_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic nvm_valid = 1'b0;
  logic ext_div = 1'b0;
  logic [15:0] nvm_word = 16'h0000;
  sos_pkg::sos_cmdwr_s cmd_wr = '0;
  logic cmd_valid, cmd_write, cmd_ack, select_done;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, active_word;
  sos_pkg::sos_sel_s use_stored;
  logic [31:0] rng = 32'haca0;
  int err_total = 0;
  int tests_run = 0;
  initial forever #2 clk = ~clk;
  sos_host host (.clk_i(clk), .cmd_ack_i(cmd_ack), .cmd_rdata_i(cmd_rdata),
    .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write), .cmd_code_o(cmd_code),
    .cmd_wdata_o(cmd_wdata));
  sos_top dut (.CLK_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_valid), .CMD_WRITE_I(cmd_write),
    .CMD_CODE_I(cmd_code), .CMD_WDATA_I(cmd_wdata), .NVM_VALID_I(nvm_valid),
    .NVM_WORD_I(nvm_word), .EXT_DIVIDER_I(ext_div), .CMD_WR_I(cmd_wr),
    .CMD_RDATA_O(cmd_rdata), .CMD_ACK_O(cmd_ack), .ACTIVE_WORD_O(active_word),
    .USE_STORED_O(use_stored), .SELECT_DONE_O(select_done));
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // Stored value wins where the word or the divider strap asks for it
  function automatic logic [8:0] exp_sel(input logic [15:0] w, input logic ext);
    return w[15] ? 9'h1ff : {w[11:9], w[6:2], w[0] | ext};
  endfunction
  // The compensation command retires both ramp and gain
  function automatic logic [8:0] clr(input int i);
    return i > 2 ? 9'h001 << (i + 1) : (i == 2 ? 9'h00c : 9'h001 << i);
  endfunction
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Power cycle with the stored word restored once, then the latched choice
  task automatic power_up(input logic [15:0] w, input logic ext);
    int n;
    @(posedge clk);
    #1;
    rst = 1'b1;
    nvm_valid = 1'b0;
    nvm_word = w;
    ext_div = ext;
    repeat (8) @(posedge clk);
    #1;
    `CHK({active_word, use_stored, select_done, cmd_ack}, 27'h0)
    rst = 1'b0;
    // The divider synchroniser restarts with reset; let it settle first
    repeat (5) @(posedge clk);
    #1;
    nvm_valid = 1'b1;
    n = 0;
    while (select_done !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 8) begin
        err_total++;
        end_of_test();
      end
    end
    nvm_word = ~w;
    `CHK(use_stored, exp_sel(w, ext))
    repeat (3) @(posedge clk);
    #1;
    `CHK(active_word, w & 16'h8e7d)
  endtask
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    logic [15:0] rd;
    logic ack;
    logic [8:0] ex;
    power_up(16'h0000, 1'b0);
    power_up(16'h0000, 1'b1);
    for (int k = 0; k < 32; k++) begin
      r = xs();
      w = k < 16 ? 16'h0001 << k : r[15:0];
      power_up(w, r[16]);
    end
    $display("power-up selection test done");
    power_up(16'hffff, 1'b0);
    for (int k = 0; k < 16; k++) begin
      r = xs();
      w = k == 0 ? 16'hffff : r[15:0];
      host.xfer(1'b1, 8'hd8, w, int'(r[17:16]), rd, ack);
      `CHK(ack, 1'b1)
      host.xfer(1'b0, 8'hd8, 16'h0000, 0, rd, ack);
      `CHK(rd, w & 16'h8e7d)
    end
    host.xfer(1'b1, 8'hd9, 16'h0000, 1, rd, ack);
    `CHK(ack, 1'b0)
    host.xfer(1'b0, 8'hd8, 16'h0000, 0, rd, ack);
    `CHK(rd, w & 16'h8e7d)
    `CHK(use_stored, 9'h1ff)
    $display("command port test done");
    ex = 9'h1ff;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      #1;
      cmd_wr = sos_pkg::sos_cmdwr_s'(8'h01 << i);
      @(posedge clk);
      #1;
      cmd_wr = '0;
      ex = ex & ~clr(i);
      `CHK(use_stored, ex)
    end
    $display("retire test done");
    end_of_test();
  end
endmodule
`default_nettype wire
